// ### hdl/mcil_core.sv
`timescale 1ns/1ps
module mcil_core
  import mcil_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ipl,
  input wire logic boundary,
  input wire logic cpu_err,
  input wire logic err_unretryable,
  input wire logic io_instr,
  input wire logic io_past_thr,
  input wire logic io_started,
  input wire logic attempt_ok,
  input wire logic attempt_fail,
  output logic retry_go,
  output logic io_irq,
  output logic io_cc_stored,
  input wire logic sys_dmg,
  input wire logic storage_multi,
  input wire logic ecc_single,
  input wire logic [31:0] fail_addr,
  input wire logic fail_addr_ok,
  input wire logic [7:0] bit_code,
  input wire logic bit_code_ok,
  input wire logic timer_damage_flag,
  input wire logic tod_dmg,
  input wire logic [3:0] tod_unit,
  input wire logic ext_dmg,
  input wire logic buffer_deletion_flag,
  input wire logic [15:0] degrade_cnt,
  output logic [6:0] snap_idx,
  output logic snap_ext,
  input wire logic [63:0] snap_data,
  output mcil_mem_t mem,
  input wire logic mem_ack,
  output logic mc_taken,
  output logic hard_stop
);
  typedef struct packed {
    mcil_seq_t st;
    logic psw, rmask, cmask, emask, hsen, xlen;
    logic [AW-1:0] exta;
    mcil_ev_t pend;
    logic [31:0] faddr;
    logic fok, bok;
    logic [7:0] bitc;
    logic [15:0] deg;
    logic [3:0] tod;
    logic xpend, hact, xgo, ack, taken, mreq;
    logic [63:0] code, mdat;
    logic [6:0] idx;
    logic [AW-1:0] maddr;
    logic [31:0] rdat;
  } mcil_st_t;
  mcil_st_t s, n;

  logic rt_rec, rt_exh, rt_xreq;
  logic [3:0] rt_cnt;
  mcil_ev_t ev, dm;
  logic take, xgo, hard_new, hs_trig, wr, rd;
  logic [31:0] ctrl_rd, stat_rd, ctrl_wr, exta_wr;

  // ==========================================================
  // Retry sequencer
  mcil_retry u_retry (
    .core_clk(core_clk),
    .nrst(nrst),
    .cpu_err(cpu_err),
    .err_unretryable(err_unretryable),
    .io_instr(io_instr),
    .io_past_thr(io_past_thr),
    .io_started(io_started),
    .attempt_ok(attempt_ok),
    .attempt_fail(attempt_fail),
    .retry_go(retry_go),
    .recovered(rt_rec),
    .exhausted(rt_exh),
    .ext_req(rt_xreq),
    .io_irq(io_irq),
    .io_cc_stored(io_cc_stored),
    .count(rt_cnt)
  );

  // Builds the eight-byte code; bit n of the code lands at [63-n]
  function automatic logic [63:0] mcil_code(mcil_ev_t d, logic x,
                                            logic fo, logic bo);
    logic [63:0] c;
    c = '0;
    c[63-MC_SD] = d.sd;
    c[63-MC_PD] = d.pd;
    c[63-MC_SR] = d.sr;
    c[63-MC_TD] = d.td;
    c[63-MC_CD] = d.cd;
    c[63-MC_ED] = d.ed;
    c[63-MC_AC] = d.ac;
    c[63-MC_BK] = d.bk;
    c[63-MC_SE] = d.se;
    c[63-MC_SC] = d.sc;
    c[63-MC_VADDR] = fo && (d.se || d.sc);
    c[63-MC_VBIT] = (bo && d.sc) || d.ac;
    c[15:0] = x ? EXT_LEN : 16'h0000;
    return c;
  endfunction

  // Byte lane merge for register writes
  function automatic logic [31:0] mcil_lane(logic [31:0] o, logic [31:0] v,
                                            logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Event capture and masking
  always_comb begin
    ev = '0;
    ev.sd = sys_dmg;
    ev.pd = storage_multi || rt_exh;
    ev.bk = rt_exh;
    ev.sr = rt_rec || ecc_single;
    ev.sc = ecc_single;
    ev.se = storage_multi || ext_dmg;
    ev.td = timer_damage_flag;
    ev.cd = tod_dmg;
    ev.ed = ext_dmg;
    ev.ac = buffer_deletion_flag;
    // Internal hard types pass on the enable bit alone
    dm = '0;
    dm.sd = s.psw && s.pend.sd;
    dm.pd = s.psw && s.pend.pd;
    dm.sr = s.psw && s.rmask && s.pend.sr;
    dm.td = s.psw && s.emask && s.pend.td;
    dm.cd = s.psw && s.emask && s.pend.cd;
    dm.ed = s.psw && s.emask && s.pend.ed;
    dm.ac = s.psw && s.cmask && s.pend.ac;
    dm.bk = dm.pd && s.pend.bk;
    dm.se = (dm.pd || dm.ed) && s.pend.se;
    dm.sc = dm.sr && s.pend.sc;
  end

  // Only the retry path and system damage ask for extended data, so an
  // ECC-only recovery carries one only while such a request is still pending
  assign xgo = s.xlen && s.xpend && (dm.sd || dm.pd || dm.sr);
  assign take = (s.st == S_IDLE) && boundary && (|dm);
  assign hard_new = sys_dmg || storage_multi || rt_exh;
  assign hs_trig = s.hact && s.hsen && hard_new;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
  assign rd = wb_cyc_i && wb_stb_i && !s.ack;

  // Register read views
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[CT_PSW] = s.psw;
    ctrl_rd[CT_RMASK] = s.rmask;
    ctrl_rd[CT_CMASK] = s.cmask;
    ctrl_rd[CT_EMASK] = s.emask;
    ctrl_rd[CT_HSEN] = s.hsen;
    ctrl_rd[CT_XLEN] = s.xlen;
    stat_rd = '0;
    stat_rd[9:0] = s.pend;
    stat_rd[ST_BUSY] = (s.st != S_IDLE) && (s.st != S_HALT);
    stat_rd[ST_HALT] = (s.st == S_HALT);
    stat_rd[ST_HACT] = s.hact;
    stat_rd[ST_RCNT +: 4] = rt_cnt;
    ctrl_wr = mcil_lane(ctrl_rd, wb_dat_i, wb_sel_i);
    exta_wr = mcil_lane(32'(s.exta), wb_dat_i, wb_sel_i);
  end

  // ==========================================================
  // Next state: bus slave, pending flags, logout sequencer
  always_comb begin
    n = s;
    n.taken = 1'b0;
    // Ack one cycle after the request; write lands on the acked edge
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (rd) begin
      unique case (wb_adr_i)
        REG_CTRL: n.rdat = ctrl_rd;
        REG_EXTA: n.rdat = 32'(s.exta);
        REG_STAT: n.rdat = stat_rd;
        REG_CODEH: n.rdat = s.code[63:32];
        REG_CODEL: n.rdat = s.code[31:0];
        default: n.rdat = '0;
      endcase
    end
    if (wr && wb_adr_i == REG_CTRL) begin
      n.psw = ctrl_wr[CT_PSW];
      n.rmask = ctrl_wr[CT_RMASK];
      n.cmask = ctrl_wr[CT_CMASK];
      n.emask = ctrl_wr[CT_EMASK];
      n.hsen = ctrl_wr[CT_HSEN];
      n.xlen = ctrl_wr[CT_XLEN];
      if (wb_sel_i[1] && wb_dat_i[CT_HDONE]) begin
        n.hact = 1'b0;
      end
    end
    if (wr && wb_adr_i == REG_EXTA) begin
      n.exta = exta_wr[AW-1:0];
    end
    // Failing data is kept with the flag that it explains
    if (ecc_single || storage_multi || ext_dmg) begin
      n.faddr = fail_addr;
      n.fok = fail_addr_ok;
      n.bitc = bit_code;
      n.bok = bit_code_ok;
    end
    if (buffer_deletion_flag) begin
      n.deg = degrade_cnt;
    end
    if (tod_dmg) begin
      n.tod = tod_unit;
    end
    unique case (s.st)
      S_IDLE: begin
        if (take) begin
          // All enabled conditions go into one code
          n.code = mcil_code(dm, xgo, s.fok, s.bok);
          n.pend = s.pend & ~dm;
          n.xgo = xgo;
          n.xpend = s.xpend && !xgo;
          n.hact = n.hact || dm.sd || dm.pd;
          n.mdat = n.code;
          n.maddr = LOG_CODE_ADDR;
          n.mreq = 1'b1;
          n.st = S_CODE;
        end
      end
      S_CODE: begin
        if (mem_ack) begin
          n.mdat = {s.faddr, s.deg, s.bitc, 4'h0, s.tod};
          n.maddr = LOG_FAIL_ADDR;
          n.st = S_FAIL;
        end
      end
      S_FAIL: begin
        if (mem_ack) begin
          n.idx = '0;
          n.maddr = LOG_FPR_ADDR;
          n.st = S_SAVE;
        end
      end
      S_SAVE: begin
        if (mem_ack) begin
          n.idx = s.idx + 7'h01;
          if (s.idx == SAVE_LAST) begin
            n.idx = '0;
            n.maddr = s.exta;
            n.st = s.xgo ? S_EXT : S_IDLE;
          end else if (n.idx == SAVE_FPR_N) begin
            n.maddr = LOG_GPR_ADDR;
          end else if (n.idx == SAVE_GPR_END) begin
            n.maddr = LOG_CR_ADDR;
          end else begin
            n.maddr = s.maddr + DW_STEP;
          end
        end
      end
      S_EXT: begin
        if (mem_ack) begin
          n.idx = s.idx + 7'h01;
          n.maddr = s.maddr + DW_STEP;
          if (s.idx == EXT_LAST) begin
            n.st = S_IDLE;
          end
        end
      end
      S_HALT: begin
        n.mreq = 1'b0;
      end
    endcase
    if ((s.st == S_SAVE || s.st == S_EXT) && n.st == S_IDLE) begin
      n.mreq = 1'b0;
      n.taken = 1'b1;
    end
    // New events set after the take clear, so none is lost
    n.pend = n.pend | ev;
    n.xpend = n.xpend || rt_xreq || sys_dmg;
    if (ipl) begin
      n.rmask = 1'b0;
      n.cmask = 1'b0;
      n.emask = 1'b1;
      n.hsen = 1'b1;
      n.xlen = 1'b1;
      n.exta = EXT_BASE_RST;
      n.hact = 1'b0;
      n.st = S_IDLE;
      n.mreq = 1'b0;
    end else if (hs_trig || s.st == S_HALT) begin
      // Nothing is written once stopped; only reset or load recovers
      n.st = S_HALT;
      n.mreq = 1'b0;
    end
  end

  // State register; reset values follow the power-on defaults
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= S_IDLE;
      s.emask <= 1'b1;
      s.hsen <= 1'b1;
      s.xlen <= 1'b1;
      s.exta <= EXT_BASE_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign snap_idx = s.idx;
  assign snap_ext = (s.st == S_EXT);
  assign mem.req = s.mreq;
  assign mem.addr = s.maddr;
  // Saved registers stream straight through to keep the area small
  assign mem.data = (s.st == S_SAVE || s.st == S_EXT) ? snap_data : s.mdat;
  assign mc_taken = s.taken;
  assign hard_stop = (s.st == S_HALT);

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_code_wr;
    mem.req && mem.addr == LOG_CODE_ADDR;
  endsequence
  sequence s_fail_wr;
    mem.req && mem.addr == LOG_FAIL_ADDR;
  endsequence

  property p_mask_all;
    !s.psw |-> !take;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("check taken with enable bit clear");

  property p_hard_always;
    s.st == S_IDLE && boundary && s.psw && s.pend.sd && !ipl && !hs_trig
    |=> s.st == S_CODE && s.code[63-MC_SD];
  endproperty
  a_hard_always: assert property (p_hard_always)
    else $error("system damage not taken");

  property p_rec_gate;
    take && dm.sr |-> s.psw && s.rmask;
  endproperty
  a_rec_gate: assert property (p_rec_gate)
    else $error("recovery check taken while masked");

  property p_ac_gate;
    take && !ipl && s.pend.ac && s.psw && s.cmask |=> s.code[63-MC_AC];
  endproperty
  a_ac_gate: assert property (p_ac_gate)
    else $error("buffer deletion bit missing");

  property p_td_gate;
    take && !ipl |=> s.code[63-MC_TD] == $past(s.emask && s.pend.td);
  endproperty
  a_td_gate: assert property (p_td_gate)
    else $error("timer damage gating wrong");

  property p_logout;
    take && !ipl && !hs_trig |=> s_code_wr ##[1:300] s_fail_wr;
  endproperty
  a_logout: assert property (p_logout)
    else $error("fixed logout not written in order");

  property p_ext_len;
    s.st == S_CODE |-> (s.code[15:0] == EXT_LEN) == s.xgo;
  endproperty
  a_ext_len: assert property (p_ext_len)
    else $error("stored extended length disagrees");

  property p_no_ecc_ext;
    take && dm.sc && !s.xpend |-> !xgo;
  endproperty
  a_no_ecc_ext: assert property (p_no_ecc_ext)
    else $error("extended logout for ECC correction");

  property p_halt;
    hard_stop && !ipl |=> hard_stop && !mem.req && !mc_taken;
  endproperty
  a_halt: assert property (p_halt)
    else $error("activity after hard stop");

  property p_ipl;
    ipl |=> s.exta == EXT_BASE_RST && !s.rmask && s.emask && s.hsen;
  endproperty
  a_ipl: assert property (p_ipl)
    else $error("load defaults wrong");
endmodule // mcil_core

// ### hdl/mcil_pkg.sv
package mcil_pkg;
  // ==========================================================
  // Storage map of the fixed and extended logout areas
  localparam int AW = 24;
  localparam logic [AW-1:0] LOG_CODE_ADDR = 24'h0000E8;
  localparam logic [AW-1:0] LOG_FAIL_ADDR = 24'h0000F8;
  localparam logic [AW-1:0] LOG_FPR_ADDR = 24'h000160;
  localparam logic [AW-1:0] LOG_GPR_ADDR = 24'h000180;
  localparam logic [AW-1:0] LOG_CR_ADDR = 24'h0001C0;
  localparam logic [AW-1:0] EXT_BASE_RST = 24'h000200;
  localparam logic [AW-1:0] DW_STEP = 24'h000008;
  localparam logic [15:0] EXT_LEN = 16'h0280;
  localparam logic [6:0] SAVE_FPR_N = 7'h04;
  localparam logic [6:0] SAVE_GPR_END = 7'h0C;
  localparam logic [6:0] SAVE_LAST = 7'h13;
  localparam logic [6:0] EXT_LAST = 7'h4F;
  // ==========================================================
  // Machine check code bit numbers, bit 0 is the MSB
  localparam int MC_SD = 0;
  localparam int MC_PD = 1;
  localparam int MC_SR = 2;
  localparam int MC_TD = 3;
  localparam int MC_CD = 4;
  localparam int MC_ED = 5;
  localparam int MC_AC = 7;
  localparam int MC_BK = 14;
  localparam int MC_SE = 16;
  localparam int MC_SC = 17;
  localparam int MC_VADDR = 24;
  localparam int MC_VBIT = 25;
  // ==========================================================
  // Register offsets and control field layout
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EXTA = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CODEH = 8'h0C;
  localparam logic [7:0] REG_CODEL = 8'h10;
  localparam int CT_PSW = 0;
  localparam int CT_RMASK = 1;
  localparam int CT_CMASK = 2;
  localparam int CT_EMASK = 3;
  localparam int CT_HSEN = 4;
  localparam int CT_XLEN = 5;
  localparam int CT_HDONE = 8;
  localparam int ST_BUSY = 10;
  localparam int ST_HALT = 11;
  localparam int ST_HACT = 12;
  localparam int ST_RCNT = 16;
  localparam logic [3:0] RETRY_MAX = 4'h8;
  // ==========================================================
  // Types
  typedef enum {S_IDLE, S_CODE, S_FAIL, S_SAVE, S_EXT, S_HALT} mcil_seq_t;
  typedef struct packed {
    logic sd, pd, sr, td, cd, ed, ac, bk, se, sc;
  } mcil_ev_t;
  typedef struct packed {
    logic req;
    logic [AW-1:0] addr;
    logic [63:0] data;
  } mcil_mem_t;
endpackage

// ### hdl/mcil_retry.sv
`timescale 1ns/1ps
// ============================================================
// Instruction retry sequencer
module mcil_retry
  import mcil_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cpu_err,
  input wire logic err_unretryable,
  input wire logic io_instr,
  input wire logic io_past_thr,
  input wire logic io_started,
  input wire logic attempt_ok,
  input wire logic attempt_fail,
  output logic retry_go,
  output logic recovered,
  output logic exhausted,
  output logic ext_req,
  output logic io_irq,
  output logic io_cc_stored,
  output logic [3:0] count
);
  typedef struct packed {
    logic busy, go, rec, exh, xr, irq, cc;
    logic [3:0] cnt;
  } mcil_rt_t;
  mcil_rt_t s, n;

  // One pass per attempt; log data follows attempts one and eight
  always_comb begin
    n = s;
    n.go = 1'b0;
    n.rec = 1'b0;
    n.exh = 1'b0;
    n.xr = 1'b0;
    n.irq = 1'b0;
    n.cc = 1'b0;
    if (!s.busy && cpu_err) begin
      if (err_unretryable) begin
        n.exh = 1'b1;
      end else if (io_instr && io_past_thr) begin
        n.irq = io_started;
        n.cc = !io_started;
      end else begin
        n.busy = 1'b1;
        n.go = 1'b1;
        n.cnt = 4'h1;
      end
    end else if (s.busy && (attempt_ok || attempt_fail)) begin
      n.xr = (s.cnt == 4'h1) || (s.cnt == RETRY_MAX);
      if (attempt_ok) begin
        n.busy = 1'b0;
        n.rec = 1'b1;
      end else if (s.cnt == RETRY_MAX) begin
        n.busy = 1'b0;
        n.exh = 1'b1;
      end else begin
        n.cnt = s.cnt + 4'h1;
        n.go = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign retry_go = s.go;
  assign recovered = s.rec;
  assign exhausted = s.exh;
  assign ext_req = s.xr;
  assign io_irq = s.irq;
  assign io_cc_stored = s.cc;
  assign count = s.cnt;

  // ==========================================================
  // Checks
  property p_retry_limit;
    @(posedge core_clk) disable iff (!nrst)
      s.busy && attempt_fail && s.cnt != RETRY_MAX |=> retry_go && !exhausted;
  endproperty
  a_retry_limit: assert property (p_retry_limit)
    else $error("retry stopped before the eighth attempt");

  property p_io_no_retry;
    @(posedge core_clk) disable iff (!nrst)
      !s.busy && cpu_err && !err_unretryable && io_instr && io_past_thr
      |=> !retry_go && (io_irq || io_cc_stored);
  endproperty
  a_io_no_retry: assert property (p_io_no_retry)
    else $error("I/O instruction past threshold was retried");
endmodule // mcil_retry

// ### testbench/tb.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the machine check logic
module tb
  import mcil_pkg::*;
  ;
  logic core_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ipl = 1'b0, boundary = 1'b0, ok = 1'b0, fl = 1'b0, mem_ack = 1'b0;
  logic fok = 1'b1, bok = 1'b1;
  logic [7:0] adr = 8'h00, bc = 8'h00;
  logic [31:0] wdat = 32'h0, rd, wb_dat_o, fa = 32'h0;
  logic [15:0] deg = 16'h0000;
  logic [5:0] ev = 6'h00; // cpu, sd, ecc, deletion, timer, external
  logic [2:0] io = 3'h0;
  logic [6:0] snap_idx;
  logic snap_ext, wb_ack_o, retry_go, io_irq, io_cc_stored, mc_taken;
  logic hard_stop;
  logic [63:0] code, fw, crw;
  mcil_mem_t mem;
  int n_fail = 0, compares = 0, nfix, next, nrt, nio, ncc, nmc, nfail, t;
  localparam logic [5:0] EVS [4] = '{6'h02, 6'h01, 6'h04, 6'h08};
  localparam logic [31:0] MSK [4] = '{32'h8, 32'h8, 32'h4, 32'h2};
  localparam int BIT [4] = '{MC_TD, MC_ED, MC_AC, MC_SR};

  initial forever #5 core_clk = ~core_clk;

  mcil_core mcil_core_inst (.core_clk(core_clk), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ipl(ipl), .boundary(boundary),
    .cpu_err(ev[5]), .err_unretryable(1'b0), .io_instr(io[2]),
    .io_past_thr(io[1]), .io_started(io[0]), .attempt_ok(ok),
    .attempt_fail(fl), .retry_go(retry_go), .io_irq(io_irq),
    .io_cc_stored(io_cc_stored), .sys_dmg(ev[4]), .storage_multi(1'b0),
    .ecc_single(ev[3]), .fail_addr(fa), .fail_addr_ok(fok),
    .bit_code(bc), .bit_code_ok(bok), .timer_damage_flag(ev[1]),
    .tod_dmg(1'b0), .tod_unit(4'h0), .ext_dmg(ev[0]),
    .buffer_deletion_flag(ev[2]), .degrade_cnt(deg),
    .snap_idx(snap_idx), .snap_ext(snap_ext),
    .snap_data({snap_ext, 56'h0, snap_idx}), .mem(mem),
    .mem_ack(mem_ack), .mc_taken(mc_taken), .hard_stop(hard_stop));

  // Storage and retry responder, one ack per doubleword
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    ok <= 1'b0;
    fl <= 1'b0;
    if (mem.req === 1'b1 && !mem_ack) begin
      mem_ack <= 1'b1;
      if (mem.addr == LOG_CODE_ADDR) code <= mem.data;
      if (mem.addr == LOG_FAIL_ADDR) fw <= mem.data;
      if (mem.addr == LOG_CR_ADDR) crw <= mem.data;
      if (mem.addr < EXT_BASE_RST) nfix++;
      else next++;
    end
    if (retry_go === 1'b1) begin
      nrt++;
      if (nrt <= nfail) fl <= 1'b1;
      else ok <= 1'b1;
    end
    nio += (io_irq === 1'b1);
    ncc += (io_cc_stored === 1'b1);
    nmc += (mc_taken === 1'b1);
  end

  // ==========================================================
  // Tasks
  task test_done;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string s, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  // Classic single cycle; request held until ack is sampled at a rising
  // edge, read data taken at that same edge, then released
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 40);
    if (wb_ack_o !== 1'b1) begin
      chk("wb_ack", 1, 0);
      test_done;
    end
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task fire(input logic [5:0] e);
    nfix = 0; next = 0; nrt = 0; nmc = 0; nio = 0; ncc = 0;
    @(posedge core_clk);
    ev <= e;
    @(posedge core_clk);
    ev <= 6'h00;
  endtask

  task wait_mc(input int n, input logic e, input string s);
    int k;
    for (k = 0; k < n && mc_taken !== 1'b1; k++) @(negedge core_clk);
    chk(s, e, mc_taken);
    if (e && k == n) test_done;
    @(posedge core_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    boundary <= 1'b1;
    wb(0, REG_CTRL, 0);
    chk("ctrl_rst", 32'h38, rd & 32'h3F);
    wb(0, REG_EXTA, 0);
    chk("cr15_rst", 32'h200, rd);
    wb(1, REG_EXTA, 32'h400);
    @(posedge core_clk) ipl <= 1'b1;
    @(posedge core_clk) ipl <= 1'b0;
    wb(0, REG_EXTA, 0);
    chk("cr15_ipl", 32'h200, rd);
    wb(0, 8'hFC, 0);
    chk("unmapped", 0, rd);
    $display("test registers done");
    // Damage stays pending while the enable bit is clear
    fire(6'h10);
    wait_mc(40, 0, "psw_mask");
    wb(1, REG_CTRL, 32'h31);
    wait_mc(300, 1, "sd_take");
    chk("sd_bit", 1, code[63-MC_SD]);
    chk("fix_words", 22, nfix);
    chk("ext_words", 80, next);
    chk("ext_len", EXT_LEN, code[15:0]);
    chk("cr_save", {57'h0, 7'h0C}, crw);
    wb(1, REG_CTRL, 32'h131);
    $display("test damage done");
    // Soft types: refused under a clear mask, taken once it is set
    fa <= 32'h0012_3458;
    bc <= 8'h2A;
    deg <= 16'h0003;
    for (t = 0; t < 4; t++) begin
      wb(1, REG_CTRL, 32'h31);
      fire(EVS[t]);
      wait_mc(40, 0, "soft_mask");
      wb(1, REG_CTRL, 32'h31 | MSK[t]);
      wait_mc(300, 1, "soft_take");
      chk("soft_bit", 1, code[63-BIT[t]]);
    end
    chk("sc_bit", 1, code[63-MC_SC]);
    chk("valid", 2'b11, code[63-MC_VADDR -: 2]);
    chk("no_ext", 0, next);
    chk("fail_addr", 32'h0012_3458, fw[63:32]);
    chk("bit_code", 8'h2A, fw[15:8]);
    $display("test soft done");
    // I/O retry before threshold, then retry exhaustion
    io <= 3'h4;
    nfail = 1;
    fire(6'h20);
    wait_mc(400, 1, "retry_ok");
    chk("sr_bit", 1, code[63-MC_SR]);
    chk("sr_alone", 0, code[63-MC_SC]);
    chk("retries", 2, nrt);
    chk("ext_first", 80, next);
    io <= 3'h0;
    nfail = 99;
    fire(6'h20);
    wait_mc(600, 1, "retry_hard");
    chk("pd_bit", 1, code[63-MC_PD]);
    chk("retry_max", 8, nrt);
    // External mask on as well, so external damage joins the shared code
    wb(1, REG_CTRL, 32'h13B);
    // Past threshold: no retry, interrupt or stored status instead
    for (t = 0; t < 2; t++) begin
      io <= t ? 3'h6 : 3'h7;
      fire(6'h20);
      repeat (5) @(posedge core_clk);
      chk("io_irq", t ? 0 : 1, nio);
      chk("io_cc", t, ncc);
      chk("io_noretry", 0, nrt);
    end
    io <= 3'h0;
    $display("test retry done");
    // Two conditions at once share one code; unacked hard check halts
    fire(6'h11);
    wait_mc(400, 1, "combo");
    chk("combo_bits", 2'b11, {code[63-MC_SD], code[63-MC_ED]});
    repeat (30) @(posedge core_clk);
    chk("one_take", 1, nmc);
    fire(6'h10);
    repeat (30) @(posedge core_clk);
    chk("halt", 1, hard_stop);
    chk("no_logout", 0, nfix);
    $display("test hard stop done");
    test_done;
  end
endmodule // tb
